//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import touch_scan_pkg::*;
   localparam int TK = 50;
   logic CORE_CLK = 1'b0;
   logic RST = 1'b1;
   logic stop_exec = 1'b0;
   logic [2:0] chan_last = 3'h0;
   logic sense_pulse = 1'b0;
   logic link_enable = 1'b0;
   logic ram_wr = 1'b0;
   logic [2:0] ram_addr = 3'h0;
   logic [15:0] ram_wdata = 16'h0000;
   logic [1:0] cpu_state;
   logic cpu_run;
   logic scan_busy;
   logic [15:0] last_result;
   logic [15:0] ram_rdata;
   logic end_seen;
   logic [15:0] set_mem [8];
   logic [15:0] res_mem [8];
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   int t_set = 0;
   int n_rd = 0;
   int zero_p = 1;
   int acc = 0;
   touch_link_if lnk();
   touch_sense_end touch_sense_end_inst(.CORE_CLK(CORE_CLK), .RST(RST), .LINK(lnk),
      .STOP_EXEC(stop_exec), .CPU_STATE(cpu_state), .CPU_RUN(cpu_run), .CHAN_LAST(chan_last),
      .SENSE_PULSE(sense_pulse), .SCAN_BUSY(scan_busy), .LAST_RESULT(last_result));
   xfer_event_end #(.TICK_CYCLES_P(TK), .NCH(MAX_CHANNELS)) xfer_event_end_inst(
      .CORE_CLK(CORE_CLK), .RST(RST), .LINK(lnk), .TIMER_RUN(1'b1), .LINK_ENABLE(link_enable),
      .RAM_WR(ram_wr), .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .RAM_RDATA(ram_rdata),
      .END_SEEN(end_seen));
   touch_link_sva touch_link_sva_inst(.CORE_CLK(CORE_CLK), .RST(RST),
      .interval_tick_irq(lnk.interval_tick_irq), .settings_write_req(lnk.settings_write_req),
      .settings_done(lnk.settings_done), .settings_data(lnk.settings_data),
      .result_read_req(lnk.result_read_req), .result_done(lnk.result_done),
      .chan_idx(lnk.chan_idx), .scan_end_irq(lnk.scan_end_irq));
   initial
   begin
      forever #50 CORE_CLK = ~CORE_CLK;
   end
   task report_and_stop;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk_word(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: word %h expected %h", $time, g, e);
      end
   endtask
   task chk_bits(input logic [3:0] g, input logic [3:0] e);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: state %h expected %h", $time, g, e);
      end
   endtask
   task chk_n(input int g, input int e);
      comparisons++;
      if (g != e)
      begin
         miscompares++;
         $display("mismatch at %0t: count %0d expected %0d", $time, g, e);
      end
   endtask
   task wait_busy(input logic v);
      int i;
      for (i = 0; i < 4000 && scan_busy !== v; i++)
         @(negedge CORE_CLK);
      if (scan_busy !== v)
      begin
         miscompares++;
         report_and_stop();
      end
   endtask
   // Link monitor at mid-cycle, where the link outputs have settled.
   // It also drives the sensor pulses and counts those inside the measuring window.
   always @(negedge CORE_CLK)
   begin
      if (!RST && lnk.settings_done === 1'b1)
      begin
         chk_word(lnk.settings_data, set_mem[n_rd]);
         chk_bits({1'b0, lnk.chan_idx}, 4'(n_rd));
         t_set = cyc;
         acc = 0;
      end
      if (!RST && lnk.result_read_req === 1'b1)
      begin
         chk_n(cyc - t_set, 19 + int'(set_mem[n_rd][7:0]));
         chk_word(lnk.result_data, 16'(acc));
         if (zero_p != 0)
            chk_word(lnk.result_data, 16'h0000);
         res_mem[n_rd] = 16'(acc);
         n_rd++;
      end
      sense_pulse = (zero_p == 0) && $urandom % 2 == 1;
      if (cyc >= t_set + 2 && cyc <= t_set + 17 + int'(set_mem[n_rd][7:0]))
         acc = acc + int'(sense_pulse);
      if (!RST && lnk.scan_end_irq === 1'b1)
      begin
         chk_n(n_rd, int'(chan_last) + 1);
         n_rd = 0;
      end
      cyc++;
   end
   initial
   begin
      void'($urandom(97383));
      repeat (2) @(negedge CORE_CLK);
      RST = 1'b0;
      for (int it = 0; it < 3; it++)
      begin
         zero_p = (it == 0);
         chan_last = (it == 0) ? 3'h0 : (it == 1) ? 3'h7 : 3'($urandom);
         for (int k = 0; k < 8; k++)
         begin
            ram_wdata = 16'($urandom);
            set_mem[k] = ram_wdata;
            ram_addr = 3'(k);
            ram_wr = 1'b1;
            @(negedge CORE_CLK);
         end
         ram_wr = 1'b0;
         stop_exec = 1'b1;
         @(negedge CORE_CLK);
         stop_exec = 1'b0;
         chk_bits({cpu_state, cpu_run, end_seen}, {PWR_STOP, 2'b00});
         repeat (2 * TK) @(negedge CORE_CLK);
         chk_bits({cpu_state, cpu_run, scan_busy}, {PWR_STOP, 2'b00});
         link_enable = 1'b1;
         wait_busy(1'b1);
         chk_bits({cpu_state, cpu_run, scan_busy}, {PWR_STATE_A, 2'b01});
         wait_busy(1'b0);
         @(negedge CORE_CLK);
         chk_bits({cpu_state, cpu_run, end_seen}, {PWR_NORMAL, 2'b11});
         chk_word(last_result, res_mem[chan_last]);
         link_enable = 1'b0;
         repeat (2) @(negedge CORE_CLK);
         wait_busy(1'b0);
         for (int k = 0; k <= int'(chan_last); k++)
         begin
            ram_addr = 3'(k);
            @(negedge CORE_CLK);
            chk_word(ram_rdata, res_mem[k]);
         end
      end
      report_and_stop();
   end
endmodule
`default_nettype wire

//--- dv/touch_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module touch_link_sva
   import touch_scan_pkg::*;
(
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // Link signals.
   input wire logic interval_tick_irq,
   input wire logic settings_write_req,
   input wire logic settings_done,
   input wire logic [DATA_W-1:0] settings_data,
   input wire logic result_read_req,
   input wire logic result_done,
   input wire logic [CHAN_W-1:0] chan_idx,
   input wire logic scan_end_irq
);
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   logic busy_reg;
   logic [8:0] cnt_reg;
   logic [7:0] settle_reg;
   // Tracks the scan in progress and the cycles since the last settings load.
   always_ff @(posedge CORE_CLK)
   begin
      busy_reg <= !RST && (busy_reg || settings_write_req) && !scan_end_irq;
      cnt_reg <= settings_done ? 9'h001 : cnt_reg + 9'h001;
      if (settings_done)
      begin
         settle_reg <= settings_data[7:0];
      end
   end
   a_tick_wakes: assert property (interval_tick_irq && (!busy_reg || scan_end_irq)
      && !settings_write_req
      |=> settings_write_req && chan_idx == 3'h0) else $error("tick did not start a scan");
   a_tick_ignored: assert property (interval_tick_irq && busy_reg && !result_done
      && !scan_end_irq
      |=> !settings_write_req) else $error("tick accepted during a scan");
   a_settings_answer: assert property (settings_write_req |=> settings_done)
      else $error("settings not delivered");
   a_result_answer: assert property (result_read_req |=> result_done)
      else $error("result not stored");
   a_measure_len: assert property (result_read_req
      |-> cnt_reg == 9'h013 + {1'b0, settle_reg}) else $error("measure length wrong");
   a_measure_bound: assert property (settings_done |-> ##[19:274] result_read_req)
      else $error("measurement never ended");
   a_after_result: assert property (result_done |=> settings_write_req || scan_end_irq)
      else $error("scan stalled after result");
   a_end_follows: assert property (scan_end_irq |-> $past(result_done))
      else $error("end irq without result");
   a_req_pulse: assert property (settings_write_req |=> !settings_write_req)
      else $error("write request too long");
   c_scan_end: cover property (scan_end_irq);
   c_tick_busy: cover property (interval_tick_irq && busy_reg);
   c_last_chan: cover property (settings_write_req && chan_idx == 3'h7);
endmodule
`default_nettype wire

//--- hdl/cap_meas_counter.sv
`timescale 1ns/1ps
`default_nettype none
module cap_meas_counter
   import touch_scan_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Control.
   input wire logic start,
   input wire logic [SETTLE_W-1:0] settle,
   input wire logic sense_pulse,
   // Answer.
   output logic done,
   output logic [DATA_W-1:0] count
);
   typedef struct packed {
      logic busy;
      logic [SETTLE_W:0] left;
      logic [DATA_W-1:0] acc;
      logic done;
   } meas_t;

   meas_t st_reg;
   meas_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (start)
      begin
         st_next.busy = 1'b1;
         st_next.left = (SETTLE_W+1)'(MEAS_BASE_CYCLES - 1) + {1'b0, settle};
         st_next.acc = RESULT_RESET;
      end
      else if (st_reg.busy)
      begin
         if (sense_pulse)
         begin
            st_next.acc = st_reg.acc + 16'h0001;
         end
         if (st_reg.left == '0)
         begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end
         else
         begin
            st_next.left = st_reg.left - 9'h001;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= '{busy: 1'b0, left: '0, acc: RESULT_RESET, done: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign done = st_reg.done;
   assign count = st_reg.acc;
endmodule
`default_nettype wire

//--- hdl/touch_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface touch_link_if;
   import touch_scan_pkg::*;
   logic interval_tick_irq;
   logic settings_write_req;
   logic settings_done;
   logic [DATA_W-1:0] settings_data;
   logic result_read_req;
   logic result_done;
   logic [DATA_W-1:0] result_data;
   logic [CHAN_W-1:0] chan_idx;
   logic scan_end_irq;

   modport sense_end (
      input interval_tick_irq,
      output settings_write_req,
      input settings_done,
      input settings_data,
      output result_read_req,
      input result_done,
      output result_data,
      output chan_idx,
      output scan_end_irq
   );

   modport xfer_end (
      output interval_tick_irq,
      input settings_write_req,
      output settings_done,
      output settings_data,
      input result_read_req,
      output result_done,
      input result_data,
      input chan_idx,
      input scan_end_irq
   );
endinterface
`default_nettype wire

//--- hdl/touch_scan_pkg.sv
package touch_scan_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_PERIOD_MS = 100;
   // Cycles between two interval ticks, derived from the period and the clock rate.
   localparam int TICK_CYCLES = TICK_PERIOD_MS * (CLK_HZ / 1000);
   localparam int MAX_CHANNELS = 8;
   localparam int CHAN_W = 3;
   localparam int DATA_W = 16;
   localparam int MEAS_BASE_CYCLES = 16;
   localparam int SETTLE_POS = 0;
   localparam int SETTLE_W = 8;
   localparam logic [DATA_W-1:0] SETTINGS_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;

   typedef enum logic [1:0] {PWR_NORMAL, PWR_STOP, PWR_STATE_A} pwr_t;
   typedef enum logic [1:0] {SC_SUSPEND, SC_WAIT_SET, SC_MEASURE, SC_WAIT_RD} scan_t;
endpackage

//--- hdl/touch_sense_end.sv
`timescale 1ns/1ps
`default_nettype none
module touch_sense_end
   import touch_scan_pkg::*;
(
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // Link to the transfer side.
   touch_link_if.sense_end LINK,
   // CPU side.
   input wire logic STOP_EXEC,
   output logic [1:0] CPU_STATE,
   output logic CPU_RUN,
   // Scan configuration and status.
   input wire logic [CHAN_W-1:0] CHAN_LAST,
   input wire logic SENSE_PULSE,
   output logic SCAN_BUSY,
   output logic [DATA_W-1:0] LAST_RESULT
);
   typedef struct packed {
      scan_t scan;
      pwr_t pwr;
      logic cpu_run;
      logic busy;
      logic [CHAN_W-1:0] chan;
      logic [DATA_W-1:0] settings;
      logic [DATA_W-1:0] result;
      logic wr_req;
      logic rd_req;
      logic end_irq;
      logic meas_start;
   } sense_t;

   sense_t st_reg;
   sense_t st_next;
   logic meas_done;
   logic [DATA_W-1:0] meas_count;

   cap_meas_counter u_meas (
      .clk(CORE_CLK),
      .rst(RST),
      .start(st_reg.meas_start),
      .settle(st_reg.settings[SETTLE_POS +: SETTLE_W]),
      .sense_pulse(SENSE_PULSE),
      .done(meas_done),
      .count(meas_count)
   );

   always_comb
   begin
      st_next = st_reg;
      st_next.wr_req = 1'b0;
      st_next.rd_req = 1'b0;
      st_next.end_irq = 1'b0;
      st_next.meas_start = 1'b0;
      unique case (st_reg.scan)
         SC_SUSPEND:
         begin
            // Only a tick leaves this state, whatever the CPU is doing.
            if (LINK.interval_tick_irq)
            begin
               st_next.scan = SC_WAIT_SET;
               st_next.busy = 1'b1;
               st_next.chan = '0;
               st_next.wr_req = 1'b1;
               if (st_reg.pwr == PWR_STOP)
               begin
                  st_next.pwr = PWR_STATE_A;
               end
            end
         end
         SC_WAIT_SET:
         begin
            if (LINK.settings_done)
            begin
               st_next.settings = LINK.settings_data;
               st_next.meas_start = 1'b1;
               st_next.scan = SC_MEASURE;
            end
         end
         SC_MEASURE:
         begin
            if (meas_done)
            begin
               st_next.result = meas_count;
               st_next.rd_req = 1'b1;
               st_next.scan = SC_WAIT_RD;
            end
         end
         SC_WAIT_RD:
         begin
            if (LINK.result_done)
            begin
               if (st_reg.chan == CHAN_LAST)
               begin
                  st_next.end_irq = 1'b1;
                  st_next.scan = SC_SUSPEND;
                  st_next.busy = 1'b0;
                  if (st_reg.pwr == PWR_STATE_A)
                  begin
                     st_next.pwr = PWR_NORMAL;
                  end
               end
               else
               begin
                  st_next.chan = st_reg.chan + 3'h1;
                  st_next.wr_req = 1'b1;
                  st_next.scan = SC_WAIT_SET;
               end
            end
         end
      endcase
      // Ticks outside the suspended state fall through unused.
      if (STOP_EXEC && st_reg.pwr == PWR_NORMAL)
      begin
         st_next.pwr = PWR_STOP;
      end
      st_next.cpu_run = (st_next.pwr == PWR_NORMAL);
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         st_reg <= '{scan: SC_SUSPEND, pwr: PWR_NORMAL, cpu_run: 1'b1, busy: 1'b0,
                     chan: '0, settings: SETTINGS_RESET, result: RESULT_RESET,
                     wr_req: 1'b0, rd_req: 1'b0, end_irq: 1'b0, meas_start: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign LINK.settings_write_req = st_reg.wr_req;
   assign LINK.result_read_req = st_reg.rd_req;
   assign LINK.result_data = st_reg.result;
   assign LINK.chan_idx = st_reg.chan;
   assign LINK.scan_end_irq = st_reg.end_irq;
   assign CPU_STATE = st_reg.pwr;
   assign CPU_RUN = st_reg.cpu_run;
   assign SCAN_BUSY = st_reg.busy;
   assign LAST_RESULT = st_reg.result;
endmodule
`default_nettype wire

//--- hdl/xfer_event_end.sv
`timescale 1ns/1ps
`default_nettype none
module xfer_event_end
   import touch_scan_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES,
   parameter int NCH = MAX_CHANNELS
)
(
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // Link to the sensing side.
   touch_link_if.xfer_end LINK,
   // Timer and event routing control.
   input wire logic TIMER_RUN,
   input wire logic LINK_ENABLE,
   // Memory access for settings and results.
   input wire logic RAM_WR,
   input wire logic [CHAN_W-1:0] RAM_ADDR,
   input wire logic [DATA_W-1:0] RAM_WDATA,
   output logic [DATA_W-1:0] RAM_RDATA,
   output logic END_SEEN
);
   typedef struct packed {
      logic [31:0] timer;
      logic tick;
      logic [NCH-1:0][DATA_W-1:0] set_mem;
      logic [NCH-1:0][DATA_W-1:0] res_mem;
      logic [DATA_W-1:0] set_data;
      logic set_done;
      logic res_done;
      logic [DATA_W-1:0] rdata;
      logic end_seen;
   } xfer_t;

   xfer_t st_reg;
   xfer_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      st_next.set_done = 1'b0;
      st_next.res_done = 1'b0;
      if (TIMER_RUN)
      begin
         if (st_reg.timer == 32'(TICK_CYCLES_P - 1))
         begin
            st_next.timer = '0;
            st_next.tick = LINK_ENABLE;
         end
         else
         begin
            st_next.timer = st_reg.timer + 32'h00000001;
         end
      end
      else
      begin
         st_next.timer = '0;
      end
      if (RAM_WR)
      begin
         st_next.set_mem[RAM_ADDR] = RAM_WDATA;
      end
      if (LINK.settings_write_req)
      begin
         st_next.set_data = st_reg.set_mem[LINK.chan_idx];
         st_next.set_done = 1'b1;
      end
      if (LINK.result_read_req)
      begin
         st_next.res_mem[LINK.chan_idx] = LINK.result_data;
         st_next.res_done = 1'b1;
      end
      if (LINK.scan_end_irq)
      begin
         st_next.end_seen = 1'b1;
      end
      else if (RAM_WR)
      begin
         st_next.end_seen = 1'b0;
      end
      st_next.rdata = st_next.res_mem[RAM_ADDR];
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign LINK.interval_tick_irq = st_reg.tick;
   assign LINK.settings_data = st_reg.set_data;
   assign LINK.settings_done = st_reg.set_done;
   assign LINK.result_done = st_reg.res_done;
   assign RAM_RDATA = st_reg.rdata;
   assign END_SEEN = st_reg.end_seen;
endmodule
`default_nettype wire
